// file: bench/csp_command_status_tb_top.sv
// Self-checking bench for the command/status page registers
`timescale 1ns/1ns
`default_nettype none

module csp_command_status_tb_top;
	logic mclk, rst, hostRd, hostWr, hostRdValid, extRd, extWr, host_if_detect_pending, cmdDone;
	logic cmdStart, engPush, engPop;
	logic [2:0] hostAddrLow, linkState;
	logic [5:0] hostAddrLatch, extAddr, irqRequest, irqEnable, thresholdLevel, cmdCode;
	logic [7:0] hostWrData, hostRdData, extWrData, errorFlags, engPushData, engPopData, q;
	logic [6:0] bufCount;
	int failures = 0;
	int n_tests = 0;
	int nExtRd = 0;

	// Forwarded read pulses, counted since they stand only one cycle
	always @(posedge mclk) begin
		if (extRd === 1'b1) begin
			nExtRd++;
		end
	end

	csp_host_model host_u (.mclk(mclk), .hostRd(hostRd), .hostWr(hostWr),
		.hostAddrLow(hostAddrLow), .hostAddrLatch(hostAddrLatch), .hostWrData(hostWrData),
		.hostRdData(hostRdData), .hostRdValid(hostRdValid));

	csp_command_status dut_u (.mclk(mclk), .rst(rst), .hostRd(hostRd), .hostWr(hostWr),
		.hostAddrLow(hostAddrLow), .hostAddrLatch(hostAddrLatch), .hostWrData(hostWrData),
		.hostRdData(hostRdData), .hostRdValid(hostRdValid), .extAddr(extAddr), .extRd(extRd),
		.extWr(extWr), .extWrData(extWrData), .host_if_detect_pending(host_if_detect_pending),
		.linkState(linkState), .irqRequest(irqRequest), .irqEnable(irqEnable),
		.errorFlags(errorFlags), .thresholdLevel(thresholdLevel), .cmdDone(cmdDone),
		.cmdCode(cmdCode), .cmdStart(cmdStart), .engPush(engPush), .engPushData(engPushData),
		.engPop(engPop), .engPopData(engPopData), .bufCount(bufCount));

	// 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ****************************************
	// Shared helpers
	// ****************************************
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	// Read that gives up and closes the run if no answer comes
	task automatic rdx(input logic [2:0] lo, input logic [5:0] la);
		logic ok;
		host_u.rd(lo, la, q, ok);
		if (ok !== 1'b1) begin
			failures++;
			$display("BAD read answer expected 1 seen 0");
			summarize();
		end
	endtask : rdx

	// Extra cycle first, since status lags its inputs by one edge
	task automatic st();
		@(negedge mclk);
		rdx(3'h3, 6'h03);
	endtask : st

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rdx(3'h0, 6'h00);
		chk("page", q, 8'h80);
		st();
		chk("status", q, 8'h05);
	endtask : t_reset

	task automatic t_page();
		logic ok;
		host_u.wr(3'h0, 6'h00, 8'hFF);
		rdx(3'h0, 6'h00);
		chk("page", q, 8'h87);
		host_u.wr(3'h1, 6'h00, 8'h5A);
		chk("extWr", {7'h0, extWr}, 8'h01);
		chk("extAddr", {2'h0, extAddr}, 8'h39);
		// Foreign read: no answer here, one forwarded pulse instead
		host_u.rd(3'h5, 6'h00, q, ok);
		chk("hostRdValid", {7'h0, ok}, 8'h00);
		chk("extRd", 8'(nExtRd), 8'h01);
		chk("extAddr", {2'h0, extAddr}, 8'h3D);
		host_u.wr(3'h0, 6'h00, 8'h07);
		// Low pins point elsewhere; only the latch may decide now
		rdx(3'h1, 6'h08);
		chk("page", q, 8'h07);
		host_u.wr(3'h3, 6'h2A, 8'hC3);
		chk("extAddr", {2'h0, extAddr}, 8'h2A);
		chk("extWrData", extWrData, 8'hC3);
		host_u.wr(3'h0, 6'h30, 8'h80);
		rdx(3'h0, 6'h00);
		chk("page", q, 8'h80);
	endtask : t_page

	task automatic t_cmd();
		host_u.wr(3'h1, 6'h01, 8'hFF);
		chk("cmdStart", {7'h0, cmdStart}, 8'h01);
		chk("cmdCode", {2'h0, cmdCode}, 8'h3F);
		rdx(3'h1, 6'h01);
		chk("cmd", q, 8'hBF);
		@(negedge mclk);
		host_if_detect_pending = 1'b0;
		cmdDone = 1'b1;
		@(negedge mclk);
		cmdDone = 1'b0;
		rdx(3'h1, 6'h01);
		chk("cmd", q, 8'h00);
		host_u.wr(3'h1, 6'h01, 8'h15);
		rdx(3'h1, 6'h01);
		chk("cmd", q, 8'h15);
	endtask : t_cmd

	task automatic t_status();
		for (int i = 0; i < 8; i++) begin
			linkState = 3'(i);
			st();
			chk("link", {5'h0, q[6:4]}, 8'(i));
			chk("rsv", {7'h0, q[7]}, 8'h00);
		end
		linkState = 3'h0;
		for (int i = 0; i < 8; i++) begin
			errorFlags = 8'h01 << i;
			st();
			chk("err", {7'h0, q[2]}, 8'h01);
		end
		errorFlags = 8'h00;
		irqRequest = 6'h21;
		irqEnable = 6'h1E;
		st();
		chk("errIrq", {6'h0, q[3:2]}, 8'h00);
		irqEnable = 6'h20;
		st();
		chk("irq", {7'h0, q[3]}, 8'h01);
		// Status is read-only; a write must leave it as the inputs say
		host_u.wr(3'h3, 6'h03, 8'hFF);
		st();
		chk("status", q, 8'h09);
	endtask : t_status

	task automatic t_buf();
		thresholdLevel = 6'h04;
		for (int i = 1; i <= 65; i++) begin
			host_u.wr(3'h2, 6'h02, 8'(i));
			chk("count", {1'b0, bufCount}, 8'((i > 64) ? 64 : i));
			if (i == 4 || i == 5 || i == 59 || i == 60) begin
				st();
				chk("nearEmpty", {7'h0, q[0]}, 8'(i <= 4));
				chk("nearFull", {7'h0, q[1]}, 8'((64 - i) <= 4));
			end
		end
		engPop = 1'b1;
		@(negedge mclk);
		engPop = 1'b0;
		chk("engPopData", engPopData, 8'h01);
		for (int i = 2; i <= 64; i++) begin
			rdx(3'h2, 6'h02);
			chk("data", q, 8'(i));
		end
		chk("count", {1'b0, bufCount}, 8'h00);
		engPushData = 8'h5C;
		engPush = 1'b1;
		@(negedge mclk);
		engPush = 1'b0;
		rdx(3'h2, 6'h02);
		chk("data", q, 8'h5C);
		st();
		chk("alerts", {6'h0, q[1:0]}, 8'h01);
	endtask : t_buf

	// Reset, then the scenarios in turn
	initial begin
		rst = 1'b1;
		host_if_detect_pending = 1'b1;
		linkState = 3'h0;
		irqRequest = 6'h00;
		irqEnable = 6'h00;
		errorFlags = 8'h01;
		thresholdLevel = 6'h00;
		cmdDone = 1'b0;
		engPush = 1'b0;
		engPushData = 8'h00;
		engPop = 1'b0;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		t_reset();
		t_page();
		t_cmd();
		t_status();
		t_buf();
		summarize();
	end
endmodule : csp_command_status_tb_top

`default_nettype wire

// file: bench/csp_host_model.sv
// Host microprocessor model that drives the register port
`timescale 1ns/1ns
`default_nettype none

module csp_host_model (
	input wire logic mclk, // System clock
	output logic hostRd, // Read strobe
	output logic hostWr, // Write strobe
	output logic [2:0] hostAddrLow, // Low address bits
	output logic [5:0] hostAddrLatch, // Latch address
	output logic [7:0] hostWrData, // Write byte
	input wire logic [7:0] hostRdData, // Read byte
	input wire logic hostRdValid // Read byte valid
);
	// Idle bus from time zero
	initial begin
		hostRd = 1'b0;
		hostWr = 1'b0;
		hostAddrLow = 3'h0;
		hostAddrLatch = 6'h00;
		hostWrData = 8'h00;
	end

	// One write; strobe spans exactly one rising edge
	task automatic wr(input logic [2:0] lo, input logic [5:0] la, input logic [7:0] d);
		@(negedge mclk);
		hostAddrLow = lo;
		hostAddrLatch = la;
		hostWrData = d;
		hostWr = 1'b1;
		@(negedge mclk);
		hostWr = 1'b0;
		hostWrData = ~d; // Stale byte must not pass for the written one
	endtask : wr

	// One read; the answer is awaited under a two-cycle bound
	task automatic rd(input logic [2:0] lo, input logic [5:0] la, output logic [7:0] q,
		output logic ok);
		int i;
		@(negedge mclk);
		hostAddrLow = lo;
		hostAddrLatch = la;
		hostRd = 1'b1;
		@(negedge mclk);
		hostRd = 1'b0;
		ok = 1'b0;
		q = 8'h00;
		for (i = 0; i < 2 && !ok; i++) begin
			if (hostRdValid === 1'b1) begin
				ok = 1'b1;
				q = hostRdData;
			end else begin
				@(negedge mclk);
			end
		end
	endtask : rd
endmodule : csp_host_model

`default_nettype wire

// file: rtl/csp_byte_buffer.sv
// Circular byte buffer with occupancy count
`timescale 1ns/1ns
`default_nettype none

module csp_byte_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64,
	localparam int AW = $clog2(DEPTH)
) (
	input wire logic mclk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic pushEn, // Write one entry
	input wire logic [WIDTH-1:0] pushData, // Entry to write
	input wire logic popEn, // Remove head entry
	output logic [WIDTH-1:0] headData, // Oldest entry
	output logic [AW:0] count // Entries held
);

	// Pointers wrap naturally, so depth must be a power of two
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("csp_byte_buffer: DEPTH must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [AW:0] count_q, count_d;
	logic doPush, doPop;

	// Push to a full buffer and pop from an empty one are dropped
	always_comb begin
		doPush = pushEn && (count_q != (AW+1)'(DEPTH));
		doPop = popEn && (count_q != '0);
		wrPtr_d = doPush ? wrPtr_q + 1'b1 : wrPtr_q;
		rdPtr_d = doPop ? rdPtr_q + 1'b1 : rdPtr_q;
		count_d = count_q;
		if (doPush && !doPop) begin
			count_d = count_q + 1'b1;
		end else if (doPop && !doPush) begin
			count_d = count_q - 1'b1;
		end
	end

	// Pointer and count registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
		end
	end

	// Storage has no reset; headData shows the entry at the read pointer even when the buffer is empty
	always_ff @(posedge mclk) begin
		if (doPush) begin
			mem[wrPtr_q] <= pushData;
		end
	end

	assign headData = mem[rdPtr_q];
	assign count = count_q;

	// ****************************************
	// Checks
	// ****************************************
	property p_bufNoOverflow;
		@(posedge mclk) disable iff (rst) count_q <= (AW+1)'(DEPTH);
	endproperty
	a_bufNoOverflow: assert property (p_bufNoOverflow) else $error("buffer count above depth");

endmodule : csp_byte_buffer

`default_nettype wire

// file: rtl/csp_command_status.sv
// Page select, command, data port and primary state registers
// What this block does
// - Page register decoded at every multiple of eight, 00h to 38h; resets to 80h.
// - Page enable set: address bits 5..3 come from page number, low bits from pins.
// - Page enable clear: whole address comes from the internal address latch.
// - Command bit 7 reads 1 while interface detection runs, 0 once done.
// - Writing the six-bit command field starts it; reading returns running command.
// - One data port address pushes on write and pops on read of the buffer.
// - Link state bits 6..4: 0 idle, 1 start, 2 payload, 3 end of frame.
// - Link state 4 during receiver transitions, 5 during receive delay wait.
// - Link state 6 when receiver armed, 7 while receiving data.
// - Idle code means neither transmitter nor receiver active or holding data.
// - Status bit 3 set when any enabled interrupt source is requesting.
// - Status bit 2 is the OR of all error flags.
// - Near-full bit 1 set when depth minus count is at most threshold.
// - Near-empty bit 0 set when count is at most threshold.
// - Primary state register reads 05h after reset.
// - Buffer count rises on each data port write unless full or a pop lands in the same cycle, falls on each read unless empty or a push lands then.
`timescale 1ns/1ns
`default_nettype none
`include "csp_regs.svh"

module csp_command_status
	import csp_pkg::*;
#(
	parameter int BUF_DEPTH = `CSP_BUF_DEPTH,
	localparam int CW = $clog2(BUF_DEPTH) + 1
) (
	input wire logic mclk, // System clock, 100 MHz
	input wire logic rst, // Async reset, high
	input wire logic hostRd, // Host read strobe, one cycle
	input wire logic hostWr, // Host write strobe, one cycle
	input wire logic [2:0] hostAddrLow, // Low address bits, pins or latch
	input wire logic [5:0] hostAddrLatch, // Full internal address latch
	input wire logic [7:0] hostWrData, // Host write byte
	output logic [7:0] hostRdData, // Read byte
	output logic hostRdValid, // Read byte valid, one cycle
	output logic [5:0] extAddr, // Resolved address, other registers
	output logic extRd, // Read forwarded, one cycle
	output logic extWr, // Write forwarded, one cycle
	output logic [7:0] extWrData, // Forwarded write byte
	input wire logic host_if_detect_pending, // Interface detection running
	input wire logic [2:0] linkState, // Transmit/receive state code
	input wire logic [5:0] irqRequest, // Interrupt request flags
	input wire logic [5:0] irqEnable, // Interrupt mask bits
	input wire logic [7:0] errorFlags, // Error flag register
	input wire logic [5:0] thresholdLevel, // Buffer alert threshold
	input wire logic cmdDone, // Running command finished, pulse
	output logic [5:0] cmdCode, // Command now executing
	output logic cmdStart, // New command issued, one cycle
	input wire logic engPush, // Engine buffer write
	input wire logic [7:0] engPushData, // Engine byte to write
	input wire logic engPop, // Engine buffer read
	output logic [7:0] engPopData, // Byte taken by engine
	output logic [CW-1:0] bufCount // Bytes in buffer
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (BUF_DEPTH < 2 || BUF_DEPTH > 128) begin : g_chk
		$error("csp_command_status: BUF_DEPTH must be 2 to 128");
	end

	// ****************************************
	// Address resolution
	// ****************************************
	csp_page_t page_q, page_d;
	logic [5:0] effAddr;
	logic anyAcc, hitPage, hitCmd, hitData, hitStatus, hitOwn;

	// Page number replaces the upper bits only when enabled
	always_comb begin
		if (page_q.en) begin
			effAddr = {page_q.num, hostAddrLow};
		end else begin
			effAddr = hostAddrLatch;
		end
		anyAcc = hostRd || hostWr;
		hitPage = (effAddr & `CSP_PAGE_STRIDE_MASK) == `CSP_OFS_PAGE;
		hitCmd = effAddr == `CSP_OFS_CMD;
		hitData = effAddr == `CSP_OFS_DATA;
		hitStatus = effAddr == `CSP_OFS_STATUS;
		hitOwn = hitPage || hitCmd || hitData || hitStatus;
	end

	// ****************************************
	// Page select register
	// ****************************************
	// Reserved bits are masked off so they always read zero
	always_comb begin
		page_d = page_q;
		if (hostWr && hitPage) begin
			page_d = csp_page_t'(hostWrData & `CSP_PAGE_WR_MASK);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			page_q <= csp_page_t'(`CSP_PAGE_RESET);
		end else begin
			page_q <= page_d;
		end
	end

	// ****************************************
	// Command register
	// ****************************************
	logic [5:0] cmdCode_q, cmdCode_d;
	logic cmdStart_q, cmdStart_d;

	// A new command written in the finishing cycle wins over the finish
	always_comb begin
		cmdCode_d = cmdCode_q;
		cmdStart_d = 1'b0;
		if (hostWr && hitCmd) begin
			cmdCode_d = hostWrData[5:0];
			cmdStart_d = 1'b1;
		end else if (cmdDone) begin
			cmdCode_d = `CSP_CMD_IDLE;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmdCode_q <= `CSP_CMD_IDLE;
			cmdStart_q <= 1'b0;
		end else begin
			cmdCode_q <= cmdCode_d;
			cmdStart_q <= cmdStart_d;
		end
	end

	assign cmdCode = cmdCode_q;
	assign cmdStart = cmdStart_q;

	// ****************************************
	// Data port and buffer
	// ****************************************
	logic bufPush, bufPop;
	logic [7:0] bufPushData, bufHead;
	logic [7:0] engPopData_q, engPopData_d;
	logic hostPush, hostPop;

	// Host wins when both push or both pop in one cycle; the engine's push or pop is then dropped
	always_comb begin
		hostPush = hostWr && hitData;
		hostPop = hostRd && hitData;
		bufPush = hostPush || engPush;
		bufPop = hostPop || engPop;
		bufPushData = hostPush ? hostWrData : engPushData;
		engPopData_d = engPopData_q;
		if (engPop && !hostPop) begin
			engPopData_d = bufHead;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			engPopData_q <= 8'h00;
		end else begin
			engPopData_q <= engPopData_d;
		end
	end

	assign engPopData = engPopData_q;

	csp_byte_buffer #(
		.WIDTH(`CSP_BUF_WIDTH),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.mclk(mclk),
		.rst(rst),
		.pushEn(bufPush),
		.pushData(bufPushData),
		.popEn(bufPop),
		.headData(bufHead),
		.count(bufCount)
	);

	// ****************************************
	// Primary state register
	// ****************************************
	csp_status_t status_q, status_d;
	logic [7:0] freeSpace;

	// Alerts compare against the registered count, one cycle behind access
	always_comb begin
		freeSpace = 8'(BUF_DEPTH) - 8'(bufCount);
		status_d.rsv = 1'b0;
		status_d.linkState = linkState;
		status_d.irq = |(irqRequest & irqEnable);
		status_d.err = |errorFlags;
		status_d.nearFull = freeSpace <= {2'b00, thresholdLevel};
		status_d.nearEmpty = 8'(bufCount) <= {2'b00, thresholdLevel};
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			status_q <= csp_status_t'(`CSP_STATUS_RESET);
		end else begin
			status_q <= status_d;
		end
	end

	// ****************************************
	// Read data and forwarding
	// ****************************************
	logic [7:0] rdData_q, rdData_d;
	logic rdValid_q, rdValid_d;
	logic [5:0] extAddr_q, extAddr_d;
	logic extRd_q, extRd_d, extWr_q, extWr_d;
	logic [7:0] extWrData_q, extWrData_d;

	// Accesses outside this page's four registers go to the rest of the chip
	always_comb begin
		rdData_d = rdData_q;
		rdValid_d = hostRd && hitOwn;
		if (hostRd) begin
			if (hitPage) begin
				rdData_d = page_q;
			end else if (hitCmd) begin
				rdData_d = {host_if_detect_pending, 1'b0, cmdCode_q};
			end else if (hitData) begin
				rdData_d = bufHead;
			end else if (hitStatus) begin
				rdData_d = status_q;
			end
		end
		extAddr_d = anyAcc ? effAddr : extAddr_q;
		extRd_d = hostRd && !hitOwn;
		extWr_d = hostWr && !hitOwn;
		extWrData_d = hostWr ? hostWrData : extWrData_q;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdData_q <= 8'h00;
			rdValid_q <= 1'b0;
			extAddr_q <= 6'h00;
			extRd_q <= 1'b0;
			extWr_q <= 1'b0;
			extWrData_q <= 8'h00;
		end else begin
			rdData_q <= rdData_d;
			rdValid_q <= rdValid_d;
			extAddr_q <= extAddr_d;
			extRd_q <= extRd_d;
			extWr_q <= extWr_d;
			extWrData_q <= extWrData_d;
		end
	end

	assign hostRdData = rdData_q;
	assign hostRdValid = rdValid_q;
	assign extAddr = extAddr_q;
	assign extRd = extRd_q;
	assign extWr = extWr_q;
	assign extWrData = extWrData_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_pageWrite;
		hostWr && hitPage |=> page_q == ($past(hostWrData) & `CSP_PAGE_WR_MASK);
	endproperty
	a_pageWrite: assert property (p_pageWrite) else $error("page write lost");

	property p_pageAddr;
		anyAcc && page_q.en |-> effAddr[5:3] == page_q.num && effAddr[2:0] == hostAddrLow;
	endproperty
	a_pageAddr: assert property (p_pageAddr) else $error("paged address wrong");

	property p_latchAddr;
		anyAcc && !page_q.en |-> effAddr == hostAddrLatch;
	endproperty
	a_latchAddr: assert property (p_latchAddr) else $error("latch address wrong");

	property p_busyRead;
		hostRd && hitCmd |=> hostRdValid && hostRdData[7] == $past(host_if_detect_pending);
	endproperty
	a_busyRead: assert property (p_busyRead) else $error("detect bit wrong");

	property p_cmdStart;
		hostWr && hitCmd |=> cmdStart && cmdCode == $past(hostWrData[5:0])
			##1 (!cmdStart || $past(hostWr && hitCmd));
	endproperty
	a_cmdStart: assert property (p_cmdStart) else $error("command start wrong");

	property p_hostPushCount;
		hostPush && !engPop && bufCount < CW'(BUF_DEPTH) |=> bufCount == $past(bufCount) + 1'b1;
	endproperty
	a_hostPushCount: assert property (p_hostPushCount) else $error("push not counted");

	property p_hostPopCount;
		hostPop && !engPush && bufCount != '0 |=> bufCount == $past(bufCount) - 1'b1;
	endproperty
	a_hostPopCount: assert property (p_hostPopCount) else $error("pop not counted");

	property p_linkState;
		1'b1 |=> status_q.linkState == $past(linkState);
	endproperty
	a_linkState: assert property (p_linkState) else $error("link state stale");

	property p_irqSummary;
		1'b1 |=> status_q.irq == |($past(irqRequest) & $past(irqEnable));
	endproperty
	a_irqSummary: assert property (p_irqSummary) else $error("irq summary wrong");

	property p_errSummary;
		1'b1 |=> status_q.err == |$past(errorFlags);
	endproperty
	a_errSummary: assert property (p_errSummary) else $error("error summary wrong");

	property p_nearFull;
		1'b1 |=> status_q.nearFull ==
			(8'(BUF_DEPTH) - 8'($past(bufCount)) <= {2'b00, $past(thresholdLevel)});
	endproperty
	a_nearFull: assert property (p_nearFull) else $error("near full wrong");

	property p_nearEmpty;
		1'b1 |=> status_q.nearEmpty == (8'($past(bufCount)) <= {2'b00, $past(thresholdLevel)});
	endproperty
	a_nearEmpty: assert property (p_nearEmpty) else $error("near empty wrong");

	property p_reservedZero;
		hostRdValid |-> ($past(hitPage) ? hostRdData[6:3] == 4'h0 : 1'b1) && !status_q.rsv;
	endproperty
	a_reservedZero: assert property (p_reservedZero) else $error("reserved bit set");

endmodule : csp_command_status

`default_nettype wire

// file: rtl/csp_pkg.sv
// Types shared by the command/status page logic
package csp_pkg;

	// Page select register layout
	typedef struct packed {
		logic en;
		logic [3:0] rsv;
		logic [2:0] num;
	} csp_page_t;

	// Primary state register layout
	typedef struct packed {
		logic rsv;
		logic [2:0] linkState;
		logic irq;
		logic err;
		logic nearFull;
		logic nearEmpty;
	} csp_status_t;

	// Link state codes
	typedef enum logic [2:0] {
		CSP_LS_IDLE = 3'h0,
		CSP_LS_SEND_START = 3'h1,
		CSP_LS_SEND_PAYLOAD = 3'h2,
		CSP_LS_SEND_END = 3'h3,
		CSP_LS_RX_TRANSITION = 3'h4,
		CSP_LS_RX_DELAY_WAIT = 3'h5,
		CSP_LS_RX_ARMED = 3'h6,
		CSP_LS_RECEIVING = 3'h7
	} csp_link_state_t;

endpackage : csp_pkg

// file: rtl/csp_regs.svh
// Offsets, field positions, reset values and sizes of the command/status page
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CSP_OFS_PAGE 6'h00
`define CSP_OFS_CMD 6'h01
`define CSP_OFS_DATA 6'h02
`define CSP_OFS_STATUS 6'h03
`define CSP_PAGE_STRIDE_MASK 6'h07

// ****************************************
// Reset values and masks
// ****************************************
`define CSP_PAGE_RESET 8'h80
`define CSP_PAGE_WR_MASK 8'h87
`define CSP_STATUS_RESET 8'h05
`define CSP_CMD_IDLE 6'h00

// ****************************************
// Field positions
// ****************************************
`define CSP_PAGE_EN_BIT 7
`define CSP_CMD_BUSY_BIT 7
`define CSP_ST_IRQ_BIT 3
`define CSP_ST_ERR_BIT 2
`define CSP_ST_HI_BIT 1
`define CSP_ST_LO_BIT 0

// ****************************************
// Buffer size
// ****************************************
`define CSP_BUF_DEPTH 64
`define CSP_BUF_WIDTH 8

`endif
